// ### core/cdse_map.svh
// constants, field positions and timing counts for the decode and standby block
// Operation
// - pending enabled interrupt before standby with interrupts off: standby is a no-operation.
// - interrupt during/after standby with interrupts off: execute, clear watchdog, set flags, wake.
// - crystal modes wait 1024 oscillator periods on wake; others skip the wait.
// - wake with interrupts on branches to 0004h, otherwise continue after standby.
// - each instruction is one 14-bit word in byte, bit or literal/control category.
// - byte operations write working register when dest is 0, file register when 1.
// - file address field selects 0x00 to 0x7F in the current bank.
// - bit field picks one bit of the addressed 8-bit register.
// - literal field is an 8-bit constant or an 11-bit jump/call target.
// - don't-care opcode bits never change the decode.
// - one instruction cycle is four oscillator periods.
// - taken tests or program counter changes take two cycles, second a no-operation.
// - any file-register instruction reads, modifies, then writes back the register; here bit tests and byte operations with dest 0 read without a file write-back.
// - the read phase on the port register counts as a port read.
// - standby is 00 0000 0110 0011, one cycle, affects both status flags.
// - clear-watchdog is 00 0000 0110 0100, one cycle, affects both status flags.
// - the watchdog clears on every wake from standby.
`ifndef CDSE_MAP_SVH
`define CDSE_MAP_SVH
`define CDSE_WORD_W        14
`define CDSE_FADDR_LSB     0
`define CDSE_FADDR_W       7
`define CDSE_DEST_BIT      7
`define CDSE_BSEL_LSB      7
`define CDSE_BSEL_W        3
`define CDSE_K8_W          8
`define CDSE_K11_W         11
`define CDSE_OP_STANDBY    14'h0063
`define CDSE_OP_CLRWD      14'h0064
`define CDSE_OP_RETURN     14'h0008
`define CDSE_OP_RETFIE     14'h0009
`define CDSE_INT_VECTOR    13'h0004
`define CDSE_PHASES        4
`define CDSE_OST_PERIODS   1024
`endif

// ### core/cdse_pkg.sv
// types for the decode and standby block
package cdse_pkg;
  typedef enum logic [1:0] {
    CAT_BYTE = 2'b00,
    CAT_BIT  = 2'b01,
    CAT_LIT  = 2'b10
  } cdse_cat_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OST   = 2'b10
  } cdse_state_t;

  typedef struct packed {
    cdse_cat_t   category;
    logic        fileOp;
    logic        destFile;
    logic [6:0]  fileAddr;
    logic [2:0]  bitSel;
    logic [7:0]  lit8;
    logic [10:0] lit11;
    logic        isStandby;
    logic        isClearWd;
    logic        isJump;
    logic        isCall;
    logic        isReturn;
    logic        isSkip;
    logic        skipOnZero;
  } cdse_dec_t;
endpackage

// ### core/cdse_phase_gen.sv
// divider that forms the four-phase instruction cycle
`timescale 1ns/1ps
`include "cdse_map.svh"
module cdse_phase_gen #(
  parameter int PHASES = `CDSE_PHASES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // control
  input  wire logic run,
  // phase outputs
  output logic      cycleEnd,
  output logic      readPhase,
  output logic      writePhase
);
  logic [1:0] phase;

  // quarter counter, held at zero while stopped so a restart is aligned
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 2'h0;
    end else if (!run) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign readPhase  = run && (phase == 2'h1);
  assign writePhase = run && (phase == 2'(PHASES - 1));
  assign cycleEnd   = writePhase;
endmodule // cdse_phase_gen

// ### core/cdse_core.sv
// instruction decode, sequencing and standby entry for the core
`timescale 1ns/1ps
`include "cdse_map.svh"
module cdse_core #(
  parameter int OST_PERIODS = `CDSE_OST_PERIODS
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // program memory side
  input  wire logic [`CDSE_WORD_W-1:0] instrWord,
  output logic [12:0]                  programCounter,
  // execution feedback
  input  wire logic                    testTrue,
  input  wire logic [12:0]             returnAddr,
  input  wire logic [1:0]              bankSelect,
  input  wire logic [8:0]              portRegAddr,
  // interrupt and mode inputs
  input  wire logic                    globalIntEnable,
  input  wire logic                    intPending,
  input  wire logic                    wdtTimeout,
  input  wire logic                    crystalMode,
  // file register access
  output logic [8:0]                   fileAddr,
  output logic [2:0]                   bitSel,
  output logic                         fileRead,
  output logic                         fileWrite,
  output logic                         workWrite,
  output logic                         portRead,
  output logic [10:0]                  literal,
  // status outputs
  output logic                         timeoutFlag,
  output logic                         powerdownFlag,
  output logic                         watchdogClear,
  output logic                         sleeping,
  output logic                         intVectorTaken
);
  cdse_pkg::cdse_dec_t   dec;
  cdse_pkg::cdse_state_t state;
  logic                  cycleEnd;
  logic                  readPhase;
  logic                  writePhase;
  logic                  flushCycle;
  logic                  flushKeepPc;
  logic                  running;
  logic [10:0]           ostCount;
  logic                  execStandby;
  logic                  wakeNow;
  logic                  wakeDone;

  // full decode of one word; x positions are never looked at
  function automatic cdse_pkg::cdse_dec_t decode(input logic [13:0] w);
    cdse_pkg::cdse_dec_t d;
    d = '0;
    d.fileAddr = w[`CDSE_FADDR_LSB +: `CDSE_FADDR_W];
    d.bitSel   = w[`CDSE_BSEL_LSB +: `CDSE_BSEL_W];
    d.lit8     = w[`CDSE_K8_W-1:0];
    d.lit11    = w[`CDSE_K11_W-1:0];
    d.destFile = w[`CDSE_DEST_BIT];
    case (w[13:12])
      2'b00: begin
        d.category  = cdse_pkg::CAT_BYTE;
        d.isStandby = (w == `CDSE_OP_STANDBY);
        d.isClearWd = (w == `CDSE_OP_CLRWD);
        d.isReturn  = (w == `CDSE_OP_RETURN) || (w == `CDSE_OP_RETFIE);
        // movwf/clrf/clrw/no-op group: only bit 7 and low bits matter
        d.fileOp    = (w[11:8] != 4'h0) || w[7];
        if (w[11:8] == 4'h1 && !w[7]) begin
          d.fileOp = 1'b0; // clear working register, bits 6:0 ignored
        end
        d.isSkip     = (w[11:8] == 4'hB) || (w[11:8] == 4'hF);
        d.skipOnZero = 1'b1;
      end
      2'b01: begin
        d.category = cdse_pkg::CAT_BIT;
        d.fileOp   = 1'b1;
        d.destFile = !w[11]; // clear and set write back, tests do not
        d.isSkip   = w[11];
      end
      2'b10: begin
        d.category = cdse_pkg::CAT_LIT;
        d.isJump   = w[11];
        d.isCall   = !w[11];
      end
      default: begin
        d.category = cdse_pkg::CAT_LIT;
        d.isReturn = (w[11:10] == 2'b01); // return with literal, bits 9:8 ignored
      end
    endcase
    return d;
  endfunction

  assign dec     = decode(instrWord);
  assign running = (state == cdse_pkg::ST_RUN);

  cdse_phase_gen u_phase (
    .clk        (clk),
    .rstn       (rstn),
    .run        (running),
    .cycleEnd   (cycleEnd),
    .readPhase  (readPhase),
    .writePhase (writePhase)
  );

  // standby with a pending enabled source and interrupts off acts as no-operation
  assign execStandby = running && cycleEnd && !flushCycle && dec.isStandby &&
                       !(intPending && !globalIntEnable);
  // a source arriving in standby always wakes, whatever the global enable
  assign wakeNow  = (state == cdse_pkg::ST_SLEEP) && (intPending || wdtTimeout);
  assign wakeDone = (state == cdse_pkg::ST_OST && ostCount == 11'(OST_PERIODS - 1)) ||
                    (wakeNow && !crystalMode);

  // standby sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= cdse_pkg::ST_RUN;
    end else begin
      case (state)
        cdse_pkg::ST_RUN: begin
          if (execStandby) begin
            state <= cdse_pkg::ST_SLEEP;
          end
        end
        cdse_pkg::ST_SLEEP: begin
          if (wakeNow) begin
            state <= crystalMode ? cdse_pkg::ST_OST : cdse_pkg::ST_RUN;
          end
        end
        cdse_pkg::ST_OST: begin
          if (wakeDone) begin
            state <= cdse_pkg::ST_RUN;
          end
        end
        default: state <= cdse_pkg::ST_RUN;
      endcase
    end
  end

  // oscillator start-up counter, one clock per oscillator period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ostCount <= 11'h000;
    end else if (state == cdse_pkg::ST_OST) begin
      ostCount <= ostCount + 11'h001;
    end else begin
      ostCount <= 11'h000;
    end
  end

  // second cycle of taken skips and branches runs as a no-operation;
  // a branch already holds its target, so only a skip steps past the dropped word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flushCycle  <= 1'b0;
      flushKeepPc <= 1'b0;
    end else if (running && cycleEnd) begin
      flushCycle  <= !flushCycle && (dec.isJump || dec.isCall || dec.isReturn ||
                                     (dec.isSkip && testTrue));
      flushKeepPc <= !flushCycle && (dec.isJump || dec.isCall || dec.isReturn);
    end
  end

  // program counter: vector on interrupt wake, in-line otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      programCounter <= 13'h0000;
      intVectorTaken <= 1'b0;
    end else begin
      intVectorTaken <= 1'b0;
      if (wakeDone && intPending && globalIntEnable) begin
        programCounter <= `CDSE_INT_VECTOR;
        intVectorTaken <= 1'b1;
      end else if (running && cycleEnd) begin
        if (flushCycle) begin
          if (!flushKeepPc) begin
            programCounter <= programCounter + 13'h0001;
          end
        end else if (dec.isJump || dec.isCall) begin
          programCounter <= {programCounter[12:11], dec.lit11};
        end else if (dec.isReturn) begin
          programCounter <= returnAddr;
        end else if (!(dec.isStandby && execStandby)) begin
          programCounter <= programCounter + 13'h0001;
        end else begin
          programCounter <= programCounter + 13'h0001;
        end
      end
    end
  end

  // file access strobes: read always precedes the write-back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fileAddr  <= 9'h000;
      bitSel    <= 3'h0;
      literal   <= 11'h000;
      fileRead  <= 1'b0;
      fileWrite <= 1'b0;
      workWrite <= 1'b0;
      portRead  <= 1'b0;
    end else begin
      fileAddr  <= {bankSelect, dec.fileAddr};
      bitSel    <= dec.bitSel;
      literal   <= dec.isJump || dec.isCall ? dec.lit11 : {3'h0, dec.lit8};
      fileRead  <= running && !flushCycle && dec.fileOp && readPhase;
      portRead  <= running && !flushCycle && dec.fileOp && readPhase &&
                   ({bankSelect, dec.fileAddr} == portRegAddr);
      fileWrite <= running && !flushCycle && dec.fileOp && dec.destFile &&
                   writePhase;
      // no-operation and control words of the byte group carry no result for the working register
      workWrite <= running && !flushCycle && writePhase &&
                   ((dec.category == cdse_pkg::CAT_BYTE && !dec.destFile &&
                     (dec.fileOp || instrWord[11:8] == 4'h1)) ||
                    (dec.category == cdse_pkg::CAT_LIT && !dec.isJump && !dec.isCall));
    end
  end

  // status flags and watchdog clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeoutFlag   <= 1'b1;
      powerdownFlag <= 1'b1;
      watchdogClear <= 1'b0;
      sleeping      <= 1'b0;
    end else begin
      sleeping      <= (state != cdse_pkg::ST_RUN);
      watchdogClear <= 1'b0;
      if (execStandby) begin
        timeoutFlag   <= 1'b1;
        powerdownFlag <= 1'b0;
        watchdogClear <= 1'b1;
      end else if (running && cycleEnd && !flushCycle && dec.isClearWd) begin
        timeoutFlag   <= 1'b1;
        powerdownFlag <= 1'b1;
        watchdogClear <= 1'b1;
      end
      if (wdtTimeout && state != cdse_pkg::ST_RUN) begin
        timeoutFlag <= 1'b0;
      end
      if (state != cdse_pkg::ST_RUN) begin
        watchdogClear <= 1'b1; // held clear through wake and start-up
      end
    end
  end
endmodule // cdse_core

// ### sim/cdse_core_asserts.sv
// assertion checker for the decode and standby core
`timescale 1ns/1ps
module cdse_core_asserts (
  // clock, reset
  input wire logic        clk,
  input wire logic        rstn,
  // observed ports
  input wire logic [12:0] programCounter,
  input wire logic [8:0]  fileAddr,
  input wire logic [8:0]  portRegAddr,
  input wire logic        fileRead,
  input wire logic        fileWrite,
  input wire logic        workWrite,
  input wire logic        portRead,
  input wire logic        timeoutFlag,
  input wire logic        powerdownFlag,
  input wire logic        watchdogClear,
  input wire logic        sleeping,
  input wire logic        intVectorTaken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // strobes belong to a four-clock cycle
  AST_READ_GAP: assert property (fileRead |=> !fileRead [*3])
    else $error("read strobes too close");
  AST_RMW: assert property (fileWrite |-> $past(fileRead, 2))
    else $error("write without read");
  AST_ONE_DEST: assert property (!(fileWrite && workWrite))
    else $error("two destinations");
  AST_PORT: assert property (portRead |-> fileRead && fileAddr == portRegAddr)
    else $error("bad port read");
  // standby entry moves both flags and clears the watchdog together
  AST_ENTRY: assert property ($fell(powerdownFlag) |-> timeoutFlag && watchdogClear)
    else $error("bad standby entry");
  AST_SLEEP_PD: assert property ($rose(sleeping) |-> !powerdownFlag)
    else $error("asleep with flag set");
  AST_WAKE_WD: assert property ($fell(sleeping) |-> $past(watchdogClear))
    else $error("watchdog not cleared");
  AST_VECTOR: assert property (intVectorTaken |-> ##[0:1] programCounter == 13'h0004)
    else $error("vector not loaded");
  // main scenarios
  COV_SLEEP: cover property ($rose(sleeping));
  COV_VEC: cover property (intVectorTaken);
  COV_PORT: cover property (portRead);
endmodule // cdse_core_asserts

bind cdse_core cdse_core_asserts chk_u (.clk(clk), .rstn(rstn),
  .programCounter(programCounter), .fileAddr(fileAddr), .portRegAddr(portRegAddr),
  .fileRead(fileRead), .fileWrite(fileWrite), .workWrite(workWrite),
  .portRead(portRead), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag),
  .watchdogClear(watchdogClear), .sleeping(sleeping), .intVectorTaken(intVectorTaken));

// ### sim/cdse_prog_mem.sv
// program memory model feeding instruction words
`timescale 1ns/1ps
module cdse_prog_mem (
  // fetch
  input wire logic [12:0] addr,
  output logic [13:0]     word
);
  // small store, upper address bits ignored; unwritten words are no-ops
  logic [13:0] mem [0:63] = '{default: 14'h0000};
  assign word = mem[addr[5:0]];
endmodule // cdse_prog_mem

// ### sim/cdse_core_test.sv
// self-checking testbench for the decode and standby core
`timescale 1ns/1ps
module cdse_core_test;
  localparam int OST = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic globalIntEnable = 1'b0;
  logic intPending = 1'b0;
  logic crystalMode = 1'b1;
  logic [13:0] instrWord;
  logic [12:0] programCounter;
  logic [8:0] fileAddr;
  logic [8:0] rdAddr;
  logic [2:0] bitSel;
  logic [2:0] rdBit;
  logic [10:0] literal;
  logic fileRead, fileWrite, workWrite, portRead, wdPrev;
  logic timeoutFlag, powerdownFlag, watchdogClear, sleeping, intVectorTaken;
  int nErrors = 0;
  int nTests = 0;
  int nRead = 0, nWrite = 0, nWork = 0, nPort = 0, nClear = 0, nVec = 0;
  int cyc;
  always #10 clk = ~clk;
  cdse_prog_mem pm_u (.addr(programCounter), .word(instrWord));
  cdse_core #(.OST_PERIODS(OST)) dut_u (.clk(clk), .rstn(rstn), .instrWord(instrWord),
    .programCounter(programCounter), .testTrue(1'b0), .returnAddr(13'h0000),
    .bankSelect(2'h1), .portRegAddr(9'h085), .globalIntEnable(globalIntEnable),
    .intPending(intPending), .wdtTimeout(1'b0), .crystalMode(crystalMode),
    .fileAddr(fileAddr), .bitSel(bitSel), .fileRead(fileRead), .fileWrite(fileWrite),
    .workWrite(workWrite), .portRead(portRead), .literal(literal), .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag), .watchdogClear(watchdogClear), .sleeping(sleeping),
    .intVectorTaken(intVectorTaken));
  // strobe counters; watchdog clears counted on rising edges since it holds while asleep
  always @(posedge clk) begin
    wdPrev <= watchdogClear;
    if (fileRead === 1'b1) begin
      nRead++;
      rdAddr <= fileAddr;
      rdBit <= bitSel;
    end
    if (fileWrite === 1'b1) nWrite++;
    if (workWrite === 1'b1) nWork++;
    if (portRead === 1'b1) nPort++;
    if (intVectorTaken === 1'b1) nVec++;
    if (watchdogClear === 1'b1 && wdPrev === 1'b0) nClear++;
  end
  task automatic check(input string what, input logic [12:0] expV, input logic [12:0] gotV);
    nTests++;
    if (gotV !== expV) begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, expV, gotV);
    end
  endtask
  task automatic wait_pc(input logic [12:0] target);
    for (int i = 0; i < 200 && programCounter !== target; i++) begin
      @(posedge clk);
      #1;
    end
    check("pc", target, programCounter);
  endtask
  task automatic wait_sleep(input logic lvl);
    for (int i = 0; i < 20 && sleeping !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    check("sleeping", {12'h0, lvl}, {12'h0, sleeping});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard at 2000 clocks, well beyond the seventy or so clocks the tests need
  initial begin
    #40000;
    nErrors++;
    end_sim();
  end
  initial begin
    pm_u.mem[0] = 14'h0A85;  // increment port register to file
    pm_u.mem[1] = 14'h0A05;  // same to working register
    pm_u.mem[2] = 14'h16A3;  // set bit 5 of 0x23
    pm_u.mem[3] = 14'h2810;  // jump to 0x10
    pm_u.mem[4] = 14'h0060;  // no-operation with its don't-care bits set
    pm_u.mem[5] = 14'h0063;
    pm_u.mem[16] = 14'h0064;
    pm_u.mem[17] = 14'h0063;
    pm_u.mem[18] = 14'h0063;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check("timeout", 13'h1, {12'h0, timeoutFlag});
    check("powerdown", 13'h1, {12'h0, powerdownFlag});
    wait_pc(13'h0010);
    check("reads", 13'd3, 13'(nRead));
    check("file writes", 13'd2, 13'(nWrite));
    check("work writes", 13'd1, 13'(nWork));
    check("port reads", 13'd2, 13'(nPort));
    check("read addr", 13'h0A3, {4'h0, rdAddr});
    check("bit", 13'd5, {10'h0, rdBit});
    check("literal", 13'h0010, {2'h0, literal});
    $display("test decode done");
    // jump target holds through the flushed cycle, then runs for one more cycle
    cyc = 0;
    while (cyc < 20 && programCounter !== 13'h0011) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    check("two-cycle jump", 13'd8, 13'(cyc));
    @(posedge clk);
    intPending <= 1'b1;
    wait_pc(13'h0012);
    check("powerdown", 13'h1, {12'h0, powerdownFlag});
    check("wd clears", 13'd1, 13'(nClear));
    @(posedge clk);
    intPending <= 1'b0;
    globalIntEnable <= 1'b1;
    wait_sleep(1'b1);
    check("powerdown", 13'h0, {12'h0, powerdownFlag});
    check("timeout", 13'h1, {12'h0, timeoutFlag});
    check("pc asleep", 13'h0013, programCounter);
    repeat (5) @(posedge clk);
    intPending <= 1'b1;
    cyc = 0;
    while (cyc < 100 && programCounter !== 13'h0004) begin
      @(posedge clk);
      cyc++;
    end
    check("start-up wait", 13'h1, {12'h0, cyc >= OST});
    intPending <= 1'b0;
    globalIntEnable <= 1'b0;
    crystalMode <= 1'b0;
    @(posedge clk);
    #1;
    check("vectors", 13'd1, 13'(nVec));
    $display("test crystal wake done");
    wait_pc(13'h0006);
    wait_sleep(1'b1);
    @(posedge clk);
    intPending <= 1'b1;
    wait_sleep(1'b0);
    check("wd clears", 13'd3, 13'(nClear));
    @(posedge clk);
    intPending <= 1'b0;
    wait_pc(13'h0007);
    check("vectors", 13'd1, 13'(nVec));
    check("work writes", 13'd1, 13'(nWork));
    $display("test plain wake done");
    end_sim();
  end
endmodule // cdse_core_test
